// ===== hw/srd_rx_deser.sv
`timescale 1ns/1ps
// How it works
// - All eight output bits change together, at the parallel clock falling edge.
// - First received bit of each byte lands on output bit 7.
// - Parallel clock runs at byte rate for whichever rate is selected.
// - In bypass, bits are taken on rising edges of the external recovered clock.
// - Frame search runs only while the framer holds frame_lost_in high.
// - Frame pulse lasts one parallel clock period on each third A2 byte.
// - After the pulse, byte boundaries follow the newly found frame.
// - Loss of signal declared after 128 consecutive zero bits.
// - Loss cleared on 16 or more transitions within 128 bit sliding window.
// - With detection on, loss of signal mutes the parallel output.
// - With detection off, no loss monitoring and no loss-of-signal muting; signal detect still mutes.
// - Signal detect low forces the whole output bus to zero.
// - Parallel clock is the bit clock divided by eight and carries each byte.
// - rate_select low gives lower rate, high gives higher rate.
module srd_rx_deser
    import srd_pkg::*;
#(
    parameter int HI_DIV = DIV_HI_RATE,
    parameter int LO_DIV = DIV_LO_RATE
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        rx_serial_in_p,
    input  wire logic        rx_serial_in_n,
    input  wire logic        ext_recovered_clk_p,
    input  wire logic        ext_recovered_clk_n,
    input  wire logic        recovery_bypass,
    input  wire logic        rate_select,
    input  wire logic        frame_lost_in,
    input  wire logic        signal_loss_detect_off,
    input  wire logic        module_signal_detect_n,
    output logic [7:0]       rx_par_data_out,
    output logic             rx_par_clk_out,
    output logic             frame_align_pulse,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             irq
);
    localparam int DW = $clog2(LO_DIV + HI_DIV + 1);
    localparam int NS = 9;

    initial
    begin
        if (HI_DIV < 1 || LO_DIV < HI_DIV)
            $error("srd_rx_deser: dividers must be >= 1 and LO_DIV >= HI_DIV");
    end

    // Reset release through two flops
    logic rst_s1_r;
    logic rst_sync_n;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_r   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_s1_r   <= 1'b1;
            rst_sync_n <= rst_s1_r;
        end
    end

    // Pin synchronisers; stage one feeds stage two only
    logic [NS-1:0] sync1_r;
    logic [NS-1:0] sync2_r;
    logic          ext_clk_d_r;

    wire  [NS-1:0] pins = {rx_serial_in_p, rx_serial_in_n, ext_recovered_clk_p, ext_recovered_clk_n,
                           recovery_bypass, rate_select, frame_lost_in, signal_loss_detect_off,
                           module_signal_detect_n};

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            sync1_r     <= '0;
            sync2_r     <= '0;
            ext_clk_d_r <= 1'b0;
        end
        else
        begin
            sync1_r     <= pins;
            sync2_r     <= sync1_r;
            ext_clk_d_r <= sync2_r[6] & ~sync2_r[5];
        end
    end

    // Differential pairs resolved as p high and n low
    wire data_bit    = sync2_r[8] & ~sync2_r[7];
    wire ext_clk     = sync2_r[6] & ~sync2_r[5];
    wire bypass      = sync2_r[4];
    wire rate_hi     = sync2_r[3];
    wire searching   = sync2_r[2];
    wire los_off     = sync2_r[1];
    wire sig_det_n   = sync2_r[0];

    // Internal recovery stands in as a divider of sys_clk; the low rate takes more clocks per bit
    logic [DW-1:0] div_r;
    wire  [DW-1:0] div_lim  = rate_hi ? DW'(HI_DIV - 1) : DW'(LO_DIV - 1);
    wire           int_tick = (div_r >= div_lim);
    wire           ext_tick = ext_clk & ~ext_clk_d_r;
    wire           bit_tick = bypass ? ext_tick : int_tick;

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            div_r <= '0;
        else
            div_r <= int_tick ? '0 : div_r + 1'b1;
    end

    // Loss-of-signal monitor and frame detector
    logic       los;
    logic       match_raw;
    logic [7:0] det_byte;

    srd_los_mon u_los
    (
        .clk         (sys_clk),
        .rst_n       (rst_sync_n),
        .bit_tick    (bit_tick),
        .bit_val     (data_bit),
        .disable_mon (los_off),
        .los         (los)
    );

    srd_frame_det u_fdet
    (
        .clk       (sys_clk),
        .rst_n     (rst_sync_n),
        .bit_tick  (bit_tick),
        .bit_val   (data_bit),
        .match     (match_raw),
        .last_byte (det_byte)
    );

    // Byte assembly and parallel clock
    logic [2:0] bit_cnt_r;
    logic [7:0] data_r;
    logic       pclk_r;
    logic       pulse_r;
    logic       mute_r;
    logic       late_r;
    logic [7:0] late_byte_r;
    logic       late_hit_r;
    logic       late_mute_r;

    wire        frame_hit = match_raw & searching;
    wire        byte_end  = bit_tick & ((bit_cnt_r == 3'(BITS_PER_BYTE - 1)) | frame_hit);
    wire        mute_now  = ~sig_det_n | (~los_off & los);
    wire [2:0]  bit_cnt_nxt = byte_end ? 3'h0 : bit_cnt_r + 3'h1;

    // A forced boundary may land while the clock is still low; that byte is then held
    // one cycle behind a short high pulse, so every bus change still sits on a fall
    wire        early_end = byte_end & ~pclk_r;
    wire        load_now  = (byte_end & pclk_r) | late_r;
    wire [7:0]  load_byte = late_r ? late_byte_r : det_byte;
    wire        load_hit  = late_r ? late_hit_r : frame_hit;
    wire        load_mute = late_r ? late_mute_r : mute_now;

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            bit_cnt_r <= 3'h0;
        else if (bit_tick)
            bit_cnt_r <= bit_cnt_nxt;
    end

    // Low for the first half byte, high for the second: divide by eight
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            pclk_r <= 1'b0;
        else if (late_r)
            pclk_r <= 1'b0;
        else if (byte_end)
            pclk_r <= ~pclk_r;
        else if (bit_tick && (bit_cnt_nxt == 3'(BITS_PER_BYTE / 2)))
            pclk_r <= 1'b1;
    end

    // Holds what an early boundary found until the delayed fall
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            late_r      <= 1'b0;
            late_byte_r <= 8'h00;
            late_hit_r  <= 1'b0;
            late_mute_r <= 1'b0;
        end
        else
        begin
            late_r <= early_end;
            if (early_end)
            begin
                late_byte_r <= det_byte;
                late_hit_r  <= frame_hit;
                late_mute_r <= mute_now;
            end
        end
    end

    // Data, mute and pulse all move at the falling edge, so a byte never tears
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            data_r <= 8'h00;
            mute_r <= 1'b0;
        end
        else if (load_now)
        begin
            data_r <= load_mute ? 8'h00 : load_byte;
            mute_r <= load_mute;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            pulse_r <= 1'b0;
        else if (load_now)
            pulse_r <= load_hit;
    end

    assign rx_par_data_out   = data_r;
    assign rx_par_clk_out    = pclk_r;
    assign frame_align_pulse = pulse_r;

    // Event capture; a frame pulse counts once, on its first cycle
    logic                los_d_r;
    logic [EV_W-1:0]     status_r;
    logic [EV_W-1:0]     mask_r;
    logic [31:0]         rdata_r;

    wire  [EV_W-1:0]     events;
    assign events[EV_FRAME]   = byte_end & frame_hit;
    assign events[EV_LOS_SET] = los & ~los_d_r;
    assign events[EV_LOS_CLR] = ~los & los_d_r;

    wire                 wr_status = reg_wr & (reg_addr == REG_STATUS);
    wire                 wr_mask   = reg_wr & (reg_addr == REG_MASK);
    wire  [EV_W-1:0]     w1c       = wr_status ? reg_wdata[EV_W-1:0] : '0;
    // Set beats clear when both land in one cycle
    wire  [EV_W-1:0]     status_nxt = (status_r & ~w1c) | events;

    wire  [4:0]          state_bits;
    assign state_bits[ST_LOS]    = los;
    assign state_bits[ST_MUTE]   = mute_r;
    assign state_bits[ST_SEARCH] = searching;
    assign state_bits[ST_RATE]   = rate_hi;
    assign state_bits[ST_BYPASS] = bypass;

    wire  [31:0]         rd_mux = (reg_addr == REG_STATUS) ? {29'h0, status_r} :
                                  (reg_addr == REG_MASK)   ? {29'h0, mask_r}   :
                                  (reg_addr == REG_STATE)  ? {27'h0, state_bits} :
                                  (reg_addr == REG_LASTB)  ? {24'h0, data_r}   : 32'h0;

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            los_d_r  <= 1'b0;
            status_r <= '0;
            mask_r   <= MASK_RST;
            rdata_r  <= 32'h0;
        end
        else
        begin
            los_d_r  <= los;
            status_r <= status_nxt;
            if (wr_mask)
                mask_r <= reg_wdata[EV_W-1:0];
            rdata_r  <= reg_rd ? rd_mux : 32'h0;
        end
    end

    assign reg_rdata = rdata_r;
    assign irq       = |(status_r & mask_r);
endmodule

// ===== pkg/srd_pkg.sv
package srd_pkg;
    // Register map, byte addresses of aligned 32-bit words
    localparam logic [3:0]  REG_STATUS  = 4'h0;
    localparam logic [3:0]  REG_MASK    = 4'h4;
    localparam logic [3:0]  REG_STATE   = 4'h8;
    localparam logic [3:0]  REG_LASTB   = 4'hC;

    // Event bits in status and mask
    localparam int          EV_FRAME    = 0;
    localparam int          EV_LOS_SET  = 1;
    localparam int          EV_LOS_CLR  = 2;
    localparam int          EV_W        = 3;
    localparam logic [2:0]  MASK_RST    = 3'h0;

    // State register fields
    localparam int          ST_LOS      = 0;
    localparam int          ST_MUTE     = 1;
    localparam int          ST_SEARCH   = 2;
    localparam int          ST_RATE     = 3;
    localparam int          ST_BYPASS   = 4;

    // Framing pattern: three A1 bytes then three A2 bytes
    localparam logic [7:0]  A1_BYTE     = 8'hF6;
    localparam logic [7:0]  A2_BYTE     = 8'h28;
    localparam int          FRAME_BYTES = 3;

    // Loss-of-signal figures, in bit periods and transitions
    localparam int          LOS_ZERO_RUN = 128;
    localparam int          LOS_WINDOW   = 128;
    localparam int          LOS_MIN_TRAN = 16;

    // Bit-tick dividers of sys_clk standing in for the recovered clock
    localparam int          DIV_HI_RATE = 1;
    localparam int          DIV_LO_RATE = 4;
    localparam int          BITS_PER_BYTE = 8;
endpackage

// ===== hw/srd_los_mon.sv
`timescale 1ns/1ps
module srd_los_mon
    import srd_pkg::*;
#(
    parameter int ZERO_RUN = LOS_ZERO_RUN,
    parameter int WINDOW   = LOS_WINDOW,
    parameter int MIN_TRAN = LOS_MIN_TRAN
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic bit_tick,
    input  wire logic bit_val,
    input  wire logic disable_mon,
    output logic      los
);
    localparam int CW = $clog2(WINDOW + 1);

    initial
    begin
        if (MIN_TRAN > WINDOW || ZERO_RUN < 1)
            $error("srd_los_mon: bad window or run length");
    end

    logic [CW-1:0]     zeros_r;
    logic [CW-1:0]     trans_r;
    logic [WINDOW-1:0] hist_r;
    logic              prev_r;
    logic              los_r;

    wire               edge_now  = bit_val ^ prev_r;
    wire               edge_old  = hist_r[WINDOW-1];
    wire [CW-1:0]      trans_nxt = trans_r + CW'(edge_now) - CW'(edge_old);
    wire [CW-1:0]      zeros_nxt = bit_val ? '0 :
                                   ((zeros_r == CW'(ZERO_RUN)) ? zeros_r : zeros_r + 1'b1);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zeros_r <= '0;
            trans_r <= '0;
            hist_r  <= '0;
            prev_r  <= 1'b0;
            los_r   <= 1'b0;
        end
        else if (bit_tick)
        begin
            prev_r  <= bit_val;
            hist_r  <= {hist_r[WINDOW-2:0], edge_now};
            trans_r <= trans_nxt;
            zeros_r <= zeros_nxt;
            if (disable_mon)
                los_r <= 1'b0;
            else if (zeros_nxt == CW'(ZERO_RUN))
                los_r <= 1'b1;
            else if (trans_nxt >= CW'(MIN_TRAN))
                los_r <= 1'b0;
        end
    end

    assign los = los_r;
endmodule

// ===== hw/srd_frame_det.sv
`timescale 1ns/1ps
module srd_frame_det
    import srd_pkg::*;
#(
    parameter int NBYTES = FRAME_BYTES
)
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic bit_tick,
    input  wire logic bit_val,
    output logic      match,
    output logic [7:0] last_byte
);
    localparam int W = 16 * NBYTES;

    initial
    begin
        if (NBYTES < 1)
            $error("srd_frame_det: need at least one framing byte");
    end

    function automatic logic [W-1:0] pattern();
        logic [W-1:0] p;
        p = '0;
        for (int i = 0; i < NBYTES; i++)
        begin
            p = {p[W-9:0], A1_BYTE};
        end
        for (int i = 0; i < NBYTES; i++)
        begin
            p = {p[W-9:0], A2_BYTE};
        end
        return p;
    endfunction

    logic [W-1:0] shift_r;

    // Earliest bit ends up in the top position of each byte
    wire  [W-1:0] shift_nxt = {shift_r[W-2:0], bit_val};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            shift_r <= '0;
        else if (bit_tick)
            shift_r <= shift_nxt;
    end

    // Compared at every bit, so any bit offset is found
    assign match     = bit_tick && (shift_nxt == pattern());
    assign last_byte = shift_nxt[7:0];
endmodule

// ===== test/srd_rx_properties.sv
`timescale 1ns/1ps
module srd_rx_properties
    import srd_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        frame_lost_in,
    input wire logic        module_signal_detect_n,
    input wire logic [7:0]  rx_par_data_out,
    input wire logic        rx_par_clk_out,
    input wire logic        frame_align_pulse,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        irq
);
    logic [7:0] mute_cnt_r;
    // Saturates so a long forced mute never wraps back to zero
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n || module_signal_detect_n)
            mute_cnt_r <= 8'h00;
        else if (mute_cnt_r != 8'hFF)
            mute_cnt_r <= mute_cnt_r + 8'h01;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_bus_moves_together: assert property (!$stable(rx_par_data_out) |-> $fell(rx_par_clk_out))
        else $error("data changed away from clock fall");
    a_pulse_on_fall: assert property ($changed(frame_align_pulse) |-> $fell(rx_par_clk_out))
        else $error("pulse edge away from clock fall");
    a_pulse_one_period: assert property ($fell(rx_par_clk_out) && $past(frame_align_pulse) |-> !frame_align_pulse)
        else $error("pulse longer than one period");
    a_pulse_needs_search: assert property ($rose(frame_align_pulse) |-> $past(frame_lost_in, 3))
        else $error("pulse without search");
    a_low_half_byte: assert property ($fell(rx_par_clk_out) && !frame_lost_in |=> !rx_par_clk_out [*3])
        else $error("parallel clock low too short");
    a_forced_mute: assert property (mute_cnt_r > 8'h30 |-> rx_par_data_out == 8'h00)
        else $error("bus not zero under forced mute");
    a_unmapped_zero: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_idle_rdata: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data without read");
    a_mask_off_irq: assert property (reg_wr && reg_addr == REG_MASK && reg_wdata[2:0] == 3'h0 |-> ##2 !irq)
        else $error("irq with all events masked");
endmodule

// ===== test/srd_line_model.sv
`timescale 1ns/1ps
module srd_line_model
(
    input  wire logic sys_clk,
    output logic      rx_serial_in_p,
    output logic      rx_serial_in_n,
    output logic      ext_recovered_clk_p,
    output logic      ext_recovered_clk_n
);
    initial
    begin
        rx_serial_in_p = 1'b0;
        rx_serial_in_n = 1'b1;
        ext_recovered_clk_p = 1'b0;
        ext_recovered_clk_n = 1'b1;
    end
    // Clock rests low between bursts; data moves mid low phase for margin
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--)
        begin
            @(posedge sys_clk);
            rx_serial_in_p <= b[i];
            rx_serial_in_n <= ~b[i];
            repeat (2) @(posedge sys_clk);
            ext_recovered_clk_p <= 1'b1;
            ext_recovered_clk_n <= 1'b0;
            @(posedge sys_clk);
            ext_recovered_clk_p <= 1'b0;
            ext_recovered_clk_n <= 1'b1;
        end
    endtask
endmodule

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
    import srd_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        recovery_bypass = 1'b1;
    logic        rate_select = 1'b0;
    logic        frame_lost_in = 1'b0;
    logic        signal_loss_detect_off = 1'b0;
    logic        module_signal_detect_n = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    wire logic   rx_serial_in_p;
    wire logic   rx_serial_in_n;
    wire logic   ext_recovered_clk_p;
    wire logic   ext_recovered_clk_n;
    logic [7:0]  rx_par_data_out;
    logic        rx_par_clk_out;
    logic        frame_align_pulse;
    logic [31:0] reg_rdata;
    logic        irq;
    int          n_fail = 0;
    int          n_tests = 0;
    logic [31:0] d;
    logic [7:0]  b;
    int          c;
    always #12.5 sys_clk = ~sys_clk;
    srd_line_model u_line (.sys_clk, .rx_serial_in_p, .rx_serial_in_n, .ext_recovered_clk_p, .ext_recovered_clk_n);
    srd_rx_deser dut (.sys_clk, .rst_n, .rx_serial_in_p, .rx_serial_in_n, .ext_recovered_clk_p,
        .ext_recovered_clk_n, .recovery_bypass, .rate_select, .frame_lost_in, .signal_loss_detect_off,
        .module_signal_detect_n, .rx_par_data_out, .rx_par_clk_out, .frame_align_pulse, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
    // Returns the byte after the next clock fall and the cycles waited from the call to that fall
    task automatic nxt(output logic [7:0] v, output int n);
        int i;
        int j;
        for (i = 0; i < 80 && rx_par_clk_out !== 1'b1; i++) @(posedge sys_clk);
        for (j = 0; j < 80 && rx_par_clk_out !== 1'b0; j++) @(posedge sys_clk);
        v = rx_par_data_out;
        n = i + j;
    endtask
    task automatic frame_run(input logic srch);
        logic [7:0] pay[4];
        logic [7:0] v;
        int i;
        foreach (pay[k]) pay[k] = 8'($urandom);
        frame_lost_in <= srch;
        fork
            begin
                u_line.send(8'($urandom), $urandom_range(7, 0));
                repeat (3) u_line.send(A1_BYTE, 8);
                repeat (3) u_line.send(A2_BYTE, 8);
                foreach (pay[k]) u_line.send(pay[k], 8);
                u_line.send(8'h5A, 8);
            end
            begin
                for (i = 0; i < 600 && frame_align_pulse !== 1'b1; i++) @(posedge sys_clk);
                chk("frame pulse", frame_align_pulse, srch);
                if (srch)
                begin
                    chk("third A2", rx_par_data_out, A2_BYTE);
                    foreach (pay[k])
                    begin
                        nxt(v, i);
                        chk("aligned byte", v, pay[k]);
                    end
                end
            end
        join
    endtask
    initial
    begin
        void'($urandom(32'he000c261));
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(REG_MASK);
        chk("mask reset", d, 32'h0);
        rd(4'h2);
        chk("unmapped", d, 32'h0);
        wr(REG_STATE, 32'h1F);
        rd(REG_STATE);
        chk("state", d, 32'h10);
        signal_loss_detect_off <= 1'b1;
        recovery_bypass <= 1'b0;
        for (int r = 0; r < 2; r++)
        begin
            rate_select <= r[0];
            repeat (3) nxt(b, c);
            chk("pclk period", c, r ? 8 * DIV_HI_RATE : 8 * DIV_LO_RATE);
        end
        recovery_bypass <= 1'b1;
        signal_loss_detect_off <= 1'b0;
        rate_select <= 1'($urandom);
        frame_run(1'b1);
        frame_run(1'b0);
        module_signal_detect_n <= 1'b0;
        repeat (3) u_line.send(8'($urandom), 8);
        chk("forced mute", rx_par_data_out, 8'h00);
        module_signal_detect_n <= 1'b1;
        wr(REG_MASK, 32'h6);
        repeat (18) u_line.send(8'h00, 8);
        rd(REG_STATE);
        chk("los muted", d[1:0], 2'h3);
        chk("irq on", irq, 1'b1);
        repeat (4) u_line.send(8'h55, 8);
        rd(REG_STATE);
        chk("los clear", d[ST_LOS], 1'b0);
        rd(REG_STATUS);
        chk("status", d, 32'h7);
        wr(REG_STATUS, 32'h7);
        rd(REG_STATUS);
        chk("status clr", d, 32'h0);
        chk("irq off", irq, 1'b0);
        signal_loss_detect_off <= 1'b1;
        repeat (17) u_line.send(8'h00, 8);
        rd(REG_STATE);
        chk("los off", d[1:0], 2'h0);
        wr(REG_MASK, 32'h0);
        conclude();
    end
    initial
    begin
        #500000;
        n_fail++;
        conclude();
    end
endmodule
bind srd_rx_deser srd_rx_properties u_prop (.sys_clk, .rst_n, .frame_lost_in, .module_signal_detect_n,
    .rx_par_data_out, .rx_par_clk_out, .frame_align_pulse, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq);
